// [rtl/aofs_top.v]
// Output format, strobe and power-down control of the sampling converter
`timescale 1ns/1ps
`include "aofs_map.vh"

// Functional notes
// - Supply select: two's complement, stabilizer off
// - Ground select: offset binary, stabilizer off
// - Two-thirds select: two's complement, stabilizer on
// - One-third select: offset binary, stabilizer on
// - Sample taken at sample clock rising edge
// - Power-down pin high stops conversion activity
// - Fourteen-bit word, bit zero is LSB
// - Output word changes at strobe falling edge
module aofs_top (
  input wire clock_i,
  input wire rst_i,
  input wire sample_clk_i,
  input wire [`AOFS_WORD_W-1:0] conv_result_i,
  input wire [`AOFS_SEL_W-1:0] format_stabilizer_select_i,
  input wire power_down_pin_i,
  output reg [`AOFS_WORD_W-1:0] sample_word_outputs_o,
  output reg data_ready_strobe_o,
  output reg duty_cycle_stabilizer_o,
  output reg core_power_down_o,
  output reg sample_overrun_o
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  reg sclk_reg;
  reg [`AOFS_SEL_W-1:0] select_reg;
  reg pd_reg;
  reg [`AOFS_WORD_W-1:0] cap_word_reg;
  reg cap_valid_reg;
  reg overrun_reg;
  reg strobe_next;
  wire sample_rise;
  wire strobe_fall;
  wire fifo_in_ready;
  wire [`AOFS_WORD_W-1:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_pop;
  wire [`AOFS_WORD_W-1:0] fmt_word;
  wire fmt_stab;

  // ------------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_reg <= `AOFS_BIT_RST;
      select_reg <= `AOFS_SEL_RST;
      pd_reg <= `AOFS_BIT_RST;
    end else begin
      sclk_reg <= sample_clk_i;
      select_reg <= format_stabilizer_select_i;
      pd_reg <= power_down_pin_i;
    end
  end

  // No capture while powered down
  assign sample_rise = sample_clk_i & ~sclk_reg & ~pd_reg;

  // ------------------------------------------------------------------
  // Capture stage
  // ------------------------------------------------------------------
  // A held word waits for buffer room; a new edge while the held word still has no room is an overrun
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cap_word_reg <= `AOFS_WORD_RST;
      cap_valid_reg <= `AOFS_BIT_RST;
      overrun_reg <= `AOFS_BIT_RST;
    end else begin
      if (sample_rise && (!cap_valid_reg || fifo_in_ready)) begin
        cap_word_reg <= conv_result_i;
        cap_valid_reg <= `AOFS_BIT_SET;
      end else if (sample_rise) begin
        overrun_reg <= `AOFS_BIT_SET;
      end else if (cap_valid_reg && fifo_in_ready) begin
        cap_valid_reg <= `AOFS_BIT_RST;
      end
      if (pd_reg) begin
        overrun_reg <= `AOFS_BIT_RST;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sample buffer
  // ------------------------------------------------------------------
  aofs_fifo #(
    .WIDTH(`AOFS_WORD_W),
    .DEPTH(`AOFS_FIFO_DEPTH),
    .AW(`AOFS_FIFO_AW),
    .CW(`AOFS_FIFO_CW)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_data_i(cap_word_reg),
    .in_valid_i(cap_valid_reg),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(strobe_fall),
    .level_o()
  );

  // ------------------------------------------------------------------
  // Format decode
  // ------------------------------------------------------------------
  aofs_format u_format (
    .select_i(select_reg),
    .offset_word_i(fifo_out_data),
    .twos_complement_o(),
    .stabilizer_on_o(fmt_stab),
    .out_word_o(fmt_word)
  );

  // ------------------------------------------------------------------
  // Strobe generation
  // ------------------------------------------------------------------
  // Strobe follows the sample clock two cycles late, so its period matches
  always @* begin
    strobe_next = sclk_reg & ~pd_reg;
  end

  assign strobe_fall = data_ready_strobe_o & ~strobe_next;
  assign fifo_pop = strobe_fall & fifo_out_valid;

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  // Word only moves at a strobe fall, leaving it stable for the rising edge
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sample_word_outputs_o <= `AOFS_WORD_RST;
      data_ready_strobe_o <= `AOFS_BIT_RST;
      duty_cycle_stabilizer_o <= `AOFS_BIT_RST;
      core_power_down_o <= `AOFS_BIT_RST;
      sample_overrun_o <= `AOFS_BIT_RST;
    end else begin
      data_ready_strobe_o <= strobe_next;
      if (fifo_pop) begin
        sample_word_outputs_o <= fmt_word;
      end
      duty_cycle_stabilizer_o <= fmt_stab;
      core_power_down_o <= pd_reg;
      sample_overrun_o <= overrun_reg;
    end
  end

endmodule // aofs_top

// [common/aofs_map.vh]
// Constants for the converter output format and strobe block
`ifndef AOFS_MAP_VH
`define AOFS_MAP_VH

// ------------------------------------------------------------------
// Data word
// ------------------------------------------------------------------
`define AOFS_WORD_W 14
`define AOFS_WORD_MSB 13
`define AOFS_WORD_RST 14'h0000

// ------------------------------------------------------------------
// Sample buffer
// ------------------------------------------------------------------
`define AOFS_FIFO_DEPTH 32
`define AOFS_FIFO_AW 5
`define AOFS_FIFO_CW 6

// ------------------------------------------------------------------
// Four-level select pin codes
// ------------------------------------------------------------------
`define AOFS_SEL_W 2
`define AOFS_SEL_GND 2'h0
`define AOFS_SEL_THIRD 2'h1
`define AOFS_SEL_TWO_THIRDS 2'h2
`define AOFS_SEL_SUPPLY 2'h3
`define AOFS_SEL_RST 2'h0

// ------------------------------------------------------------------
// Single-bit reset and set values
// ------------------------------------------------------------------
`define AOFS_BIT_RST 1'h0
`define AOFS_BIT_SET 1'h1

`endif

// [rtl/aofs_fifo.v]
// Sample buffer with valid/ready on both sides
`timescale 1ns/1ps
module aofs_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter CW = 6
) (
  input wire clock_i,
  input wire rst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [CW-1:0] level_o
);

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [CW-1:0] count_reg;
  wire do_push;
  wire do_pop;
  wire [CW-1:0] depth_c;

  assign depth_c = DEPTH[CW-1:0];
  assign in_ready_o = (count_reg != depth_c);
  assign out_valid_o = (count_reg != {CW{1'b0}});
  assign out_data_o = mem[rd_ptr_reg];
  assign level_o = count_reg;
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap naturally because depth is a power of two
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {CW{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // aofs_fifo

// [rtl/aofs_format.v]
// Select-pin decoder and output word formatter
`timescale 1ns/1ps
`include "aofs_map.vh"
module aofs_format (
  input wire [`AOFS_SEL_W-1:0] select_i,
  input wire [`AOFS_WORD_W-1:0] offset_word_i,
  output reg twos_complement_o,
  output reg stabilizer_on_o,
  output wire [`AOFS_WORD_W-1:0] out_word_o
);

  // ------------------------------------------------------------------
  // Four-level decode
  // ------------------------------------------------------------------
  always @* begin
    twos_complement_o = 1'b0;
    stabilizer_on_o = 1'b0;
    case (select_i)
      `AOFS_SEL_SUPPLY: begin
        twos_complement_o = 1'b1;
        stabilizer_on_o = 1'b0;
      end
      `AOFS_SEL_GND: begin
        twos_complement_o = 1'b0;
        stabilizer_on_o = 1'b0;
      end
      `AOFS_SEL_TWO_THIRDS: begin
        twos_complement_o = 1'b1;
        stabilizer_on_o = 1'b1;
      end
      `AOFS_SEL_THIRD: begin
        twos_complement_o = 1'b0;
        stabilizer_on_o = 1'b1;
      end
      default: begin
        twos_complement_o = 1'b0;
        stabilizer_on_o = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Offset binary to two's complement is an MSB flip
  // ------------------------------------------------------------------
  assign out_word_o = {offset_word_i[`AOFS_WORD_MSB] ^ twos_complement_o,
                       offset_word_i[`AOFS_WORD_MSB-1:0]};

endmodule // aofs_format

// [verification/aofs_props.sv]
// Port checker for the output format and strobe block
`timescale 1ns/1ps
`include "aofs_map.vh"
module aofs_props (
  input wire clock_i,
  input wire rst_i,
  input wire sample_clk_i,
  input wire [`AOFS_SEL_W-1:0] format_stabilizer_select_i,
  input wire power_down_pin_i,
  input wire [`AOFS_WORD_W-1:0] sample_word_outputs_o,
  input wire data_ready_strobe_o,
  input wire duty_cycle_stabilizer_o,
  input wire core_power_down_o
);
  default clocking dck @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_stab_on_codes: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && $stable(format_stabilizer_select_i)
    && $past(format_stabilizer_select_i) == $past(format_stabilizer_select_i, 2)
    && format_stabilizer_select_i inside {2'h1, 2'h2} |-> duty_cycle_stabilizer_o)
    else $error("stabilizer not enabled");
  a_stab_off_codes: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && $stable(format_stabilizer_select_i)
    && $past(format_stabilizer_select_i) == $past(format_stabilizer_select_i, 2)
    && format_stabilizer_select_i inside {2'h0, 2'h3} |-> !duty_cycle_stabilizer_o)
    else $error("stabilizer not disabled");
  a_pd_follow: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && $stable(power_down_pin_i)
    && $past(power_down_pin_i) == $past(power_down_pin_i, 2)
    |-> core_power_down_o == power_down_pin_i)
    else $error("power-down state wrong");
  a_pd_strobe_low: assert property (
    core_power_down_o && $past(core_power_down_o) |-> !data_ready_strobe_o)
    else $error("strobe active in power-down");
  a_strobe_rise: assert property (
    $rose(data_ready_strobe_o) |-> $past(sample_clk_i, 2))
    else $error("strobe rose without sample clock");
  a_strobe_fall: assert property (
    $fell(data_ready_strobe_o) |-> !$past(sample_clk_i, 2) || core_power_down_o)
    else $error("strobe fell early");
  a_clock_to_strobe: assert property (
    $rose(sample_clk_i) && !power_down_pin_i && !$past(power_down_pin_i)
    && !core_power_down_o |-> ##2 data_ready_strobe_o)
    else $error("strobe missing two cycles after sample edge");
  a_word_at_fall: assert property (
    !$fell(data_ready_strobe_o) |-> $stable(sample_word_outputs_o))
    else $error("word changed away from strobe fall");
endmodule // aofs_props

bind aofs_top aofs_props chk_u (.*);

// [verification/aofs_capture_model.sv]
// Capture logic model latching words on the data-ready strobe
`timescale 1ns/1ps
`include "aofs_map.vh"
module aofs_capture_model (
  input wire clock_i,
  input wire rst_i,
  input wire strobe_i,
  input wire [`AOFS_WORD_W-1:0] word_i,
  output reg [`AOFS_WORD_W-1:0] captured_word_o,
  output reg [7:0] capture_count_o
);
  reg strobe_prev_reg;
  // Rising edge sits between word changes, so the word is settled
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_prev_reg <= 1'h0;
      captured_word_o <= 14'h0000;
      capture_count_o <= 8'h00;
    end else begin
      strobe_prev_reg <= strobe_i;
      if (strobe_i && !strobe_prev_reg) begin
        captured_word_o <= word_i;
        capture_count_o <= capture_count_o + 8'h01;
      end
    end
  end
endmodule // aofs_capture_model

// [verification/aofs_top_bench.sv]
// Self-checking bench for the output format and strobe block
`timescale 1ns/1ps
`include "aofs_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module aofs_top_bench;
  reg clock_i = 1'h0;
  reg rst_i = 1'h1;
  reg sclk = 1'h0;
  reg pd = 1'h0;
  reg [13:0] conv = 14'h0000;
  reg [1:0] sel = 2'h0;
  wire [13:0] word;
  wire [13:0] cap_word;
  wire [7:0] cap_cnt;
  wire strobe;
  wire stab;
  wire core_pd;
  wire ovr;
  int failures = 0;
  int cmp_count = 0;
  always #25 clock_i = ~clock_i;
  aofs_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .sample_clk_i(sclk), .conv_result_i(conv),
    .format_stabilizer_select_i(sel), .power_down_pin_i(pd), .sample_word_outputs_o(word),
    .data_ready_strobe_o(strobe), .duty_cycle_stabilizer_o(stab), .core_power_down_o(core_pd),
    .sample_overrun_o(ovr));
  aofs_capture_model cap_u (.clock_i(clock_i), .rst_i(rst_i), .strobe_i(strobe), .word_i(word),
    .captured_word_o(cap_word), .capture_count_o(cap_cnt));
  // Input value is scrambled after the rising edge to prove it was taken there
  task send(input [13:0] v, input [7:0] inc);
    reg [7:0] n;
    n = cap_cnt;
    @(negedge clock_i);
    conv = v;
    sclk = 1'h1;
    @(negedge clock_i);
    conv = ~v;
    repeat (2) @(negedge clock_i);
    sclk = 1'h0;
    repeat (3) @(negedge clock_i);
    `CHK(cap_cnt, n + inc);
  endtask
  task check_format(input [1:0] s, input [13:0] v);
    @(negedge clock_i);
    sel = s;
    repeat (3) @(negedge clock_i);
    `CHK(stab, s == 2'h1 || s == 2'h2);
    send(v, 8'h01);
    send(14'h0155, 8'h01);
    `CHK(cap_word, v ^ {s[1], 13'h0000});
  endtask
  task power_down_test;
    reg [13:0] w;
    pd = 1'h1;
    repeat (4) @(negedge clock_i);
    `CHK(core_pd, 1'h1);
    w = word;
    send(14'h0AAA, 8'h00);
    `CHK(word, w);
    pd = 1'h0;
    repeat (4) @(negedge clock_i);
    `CHK(core_pd, 1'h0);
    send(14'h0777, 8'h01);
  endtask
  // Buffer seen through the top: words leave in order, none lost, no overrun
  task fifo_test;
    integer i;
    reg [13:0] prev;
    prev = 14'h0777 ^ {sel[1], 13'h0000};
    for (i = 0; i < 4; i++) begin
      send({12'h400, i[1:0]}, 8'h01);
      `CHK(cap_word, prev);
      prev = {12'h400, i[1:0]} ^ {sel[1], 13'h0000};
      `CHK(word, prev);
    end
    `CHK(ovr, 1'h0);
  endtask
  task stop_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a failure
  initial begin
    repeat (5000) @(posedge clock_i);
    failures++;
    stop_test;
  end
  initial begin
    repeat (5) @(negedge clock_i);
    `CHK({word, strobe, stab, core_pd}, 17'h00000);
    rst_i = 1'h0;
    check_format(2'h0, 14'h0001);
    check_format(2'h1, 14'h2000);
    check_format(2'h2, 14'h3FFE);
    check_format(2'h3, 14'h1234);
    power_down_test;
    fifo_test;
    stop_test;
  end
endmodule // aofs_top_bench
